// ===== iofd_top.sv
// Function
// - Digital output uses bit 0 of port byte
// - Status/control source ignores port byte bit 0
// - Supply fault gives 0x8000 code 0x0002
// - Undervoltage lamp red if enabled, else off
// - Actuator alarms off at reset; 0x0118
// - Actuator fault adds per-port diagnostics for active outputs
// - Sensor supply short gives port code 0x1806
// - Sensor or output short lights red port indicator
// - Auto restart: force off, retry periodically
// - Errors filtered after output rise, ms window
// - Output short gives port code 0x1811
// - Qualifier bit7 valid data, bit6 error
// - Qualifier bit5 communicating, bit4 port active
`timescale 1ns/100ps
module iofd_top
  import iofd_pkg::*;
#(
  parameter int MS_CYC_P = MS_CYC,
  parameter int RESTART_CYC = RESTART_CYC_DEF
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Cyclic output bytes, port 0 in the low byte
  input wire logic [NPORT*8-1:0] port_out_bytes,
  // Supply monitor pins
  input wire logic us_fault,
  input wire logic ul_fault,
  input wire logic us_undervolt,
  input wire logic ul_undervolt,
  // Per-port pins
  input wire logic [NPORT-1:0] sensor_short,
  input wire logic [NPORT-1:0] out_a_short,
  input wire logic [NPORT-1:0] dev_comm_in,
  input wire logic [NPORT-1:0] pd_valid_in,
  // Outputs and indicators
  output logic [NPORT-1:0] out_a_drive,
  output logic us_led_red,
  output logic ul_led_red,
  output logic [NPORT-1:0] port_fault_indicator,
  output iofd_pqi_t [NPORT-1:0] port_qualifier_byte,
  // Diagnostic stream
  output logic diag_valid,
  output iofd_diag_t diag,
  input wire logic diag_ack,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (MS_CYC_P < 1 || RESTART_CYC < 1)
  begin : g_chk
    $error("iofd_top: counts must be at least one");
  end

  localparam int NSRC = 2 + 3 * NPORT;
  localparam int SW = 4 + 4 * NPORT;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for all pins

  logic [SW-1:0] sync1_r; // First stage, read only by second
  logic [SW-1:0] sync2_r; // Safe to use
  logic [SW-1:0] sync2_d_r; // Delayed copy for edges

  // Pins are asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync2_d_r <= '0;
    end
    else
    begin
      sync1_r <= {us_fault, ul_fault, us_undervolt, ul_undervolt,
                  sensor_short, out_a_short, dev_comm_in, pd_valid_in};
      sync2_r <= sync1_r;
      sync2_d_r <= sync2_r;
    end
  end

  wire us_f = sync2_r[SW-1];
  wire ul_f = sync2_r[SW-2];
  wire us_uv = sync2_r[SW-3];
  wire ul_uv = sync2_r[SW-4];
  wire [NPORT-1:0] ls_s = sync2_r[4*NPORT-1:3*NPORT];
  wire [NPORT-1:0] cq_s = sync2_r[3*NPORT-1:2*NPORT];
  wire [NPORT-1:0] com_s = sync2_r[2*NPORT-1:NPORT];
  wire [NPORT-1:0] pdv_s = sync2_r[NPORT-1:0];
  wire us_rise = us_f & ~sync2_d_r[SW-1];
  wire ul_rise = ul_f & ~sync2_d_r[SW-2];
  wire [NPORT-1:0] ls_rise = ls_s & ~sync2_d_r[4*NPORT-1:3*NPORT];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [31:0] cfg_r; // Alarm enables and filter time
  logic [31:0] domode_r; // Output mode per port
  logic [NPORT-1:0] scout_r; // Status/control output bits
  logic [NPORT-1:0] porten_r; // Port active
  logic [IRQ_W-1:0] irqst_r; // Sticky events
  logic [IRQ_W-1:0] irqmsk_r; // Interrupt mask

  wire us_en = cfg_r[CFG_US_EN_BIT];
  wire ul_en = cfg_r[CFG_UL_EN_BIT]; // Off after reset
  wire [7:0] filt_ms = cfg_r[CFG_FILT_LSB+:8];
  wire [NPORT-1:0] is_do = domode_r[DO_EN_LSB+:NPORT];
  wire [NPORT-1:0] src_sc = domode_r[DO_SRC_LSB+:NPORT];
  wire [NPORT-1:0] rst_mode = domode_r[DO_RSTM_LSB+:NPORT];

  ////////////////////////////////////////////////////////////////////////////
  // Timebases

  logic [31:0] ms_cnt_r; // Millisecond prescaler
  logic [31:0] rs_cnt_r; // Restart retry period
  wire ms_tick = (ms_cnt_r == 32'(MS_CYC_P - 1));
  wire rs_tick = (rs_cnt_r == 32'(RESTART_CYC - 1));

  // Free-running; all ports share one retry beat to save counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms_cnt_r <= '0;
      rs_cnt_r <= '0;
    end
    else
    begin
      ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
      rs_cnt_r <= rs_tick ? 32'h0000_0000 : rs_cnt_r + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel A output control

  logic [NPORT-1:0] drive_r; // Present output state
  logic [NPORT-1:0] force_r; // Output forced off by fault
  logic [7:0] filt_cnt_r [NPORT]; // Remaining filter ms
  logic [NPORT-1:0] cmd; // Commanded level
  logic [NPORT-1:0] drive_nxt;
  logic [NPORT-1:0] filt_on; // Filter window open
  logic [NPORT-1:0] cq_trip; // Qualified short on output
  logic [NPORT-1:0] release_f; // Restart condition
  logic [NPORT-1:0] force_nxt;

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    assign cmd[p] = src_sc[p] ? scout_r[p] : port_out_bytes[8*p];
    assign drive_nxt[p] = is_do[p] & cmd[p] & porten_r[p] & ~force_r[p];
    assign filt_on[p] = (filt_cnt_r[p] != 8'h00);
    // Errors during the window are dropped, not delayed
    // A latched trip is not reported again while the output still falls
    assign cq_trip[p] = cq_s[p] & drive_r[p] & ~force_r[p] & ~filt_on[p];
    // Auto mode waits for the retry beat, reset mode for a low command
    assign release_f[p] = rst_mode[p] ? ~cmd[p] : rs_tick;
    assign force_nxt[p] = (force_r[p] & ~release_f[p]) | cq_trip[p];

    // Filter reloads on each rising edge of the output state
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        filt_cnt_r[p] <= 8'h00;
      else if (drive_nxt[p] & ~drive_r[p])
        filt_cnt_r[p] <= filt_ms;
      else if (ms_tick & filt_on[p])
        filt_cnt_r[p] <= filt_cnt_r[p] - 8'h01;
    end
  end

  // Output and fault state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_r <= '0;
      force_r <= '0;
    end
    else
    begin
      drive_r <= drive_nxt;
      force_r <= force_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic queue: one pending bit per source, lowest index first

  logic [NSRC-1:0] pend_r; // Waiting diagnostics
  logic [NSRC-1:0] pend_set;
  logic [NSRC-1:0] pend_clr;
  logic diag_valid_r; // Presented message valid
  iofd_diag_t diag_r; // Presented message

  assign pend_set[0] = us_rise;
  assign pend_set[1] = ul_rise & ul_en;
  assign pend_set[1+NPORT:2] = ls_rise;
  assign pend_set[1+2*NPORT:2+NPORT] = cq_trip;
  assign pend_set[1+3*NPORT:2+2*NPORT] = {NPORT{ul_rise & ul_en}} & drive_r;

  // Lowest pending source
  function automatic logic [7:0] first_pend(input logic [NSRC-1:0] v);
    logic [7:0] idx;
    idx = 8'hFF;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        idx = 8'(i);
    return idx;
  endfunction : first_pend

  // Message for a source index
  function automatic iofd_diag_t src_msg(input logic [7:0] s);
    iofd_diag_t m;
    m.chan = CH_GLOBAL;
    m.code = CODE_US;
    if (s == 8'h01)
      m.code = CODE_UL;
    else if (s >= 8'(2) && s < 8'(2 + NPORT))
    begin
      m.chan = 16'(s - 8'(1));
      m.code = CODE_LSHORT;
    end
    else if (s >= 8'(2 + NPORT) && s < 8'(2 + 2 * NPORT))
    begin
      m.chan = 16'(s - 8'(1 + NPORT));
      m.code = CODE_CQSHORT;
    end
    else if (s >= 8'(2 + 2 * NPORT))
    begin
      m.chan = 16'(s - 8'(1 + 2 * NPORT));
      m.code = CODE_CQSHORT;
    end
    return m;
  endfunction : src_msg

  wire [7:0] nxt_src = first_pend(pend_r);
  wire can_load = (~diag_valid_r | diag_ack) & (|pend_r);
  assign pend_clr = can_load ? (NSRC'(1) << nxt_src) : '0;

  // New events win over the clear of the bit being loaded
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r <= '0;
      diag_valid_r <= 1'b0;
      diag_r <= '0;
    end
    else
    begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
      if (can_load)
      begin
        diag_valid_r <= 1'b1;
        diag_r <= src_msg(nxt_src);
      end
      else if (diag_ack)
        diag_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators and qualifier bytes

  logic us_led_r;
  logic ul_led_r;
  logic [NPORT-1:0] pfi_r; // Red port indicators
  iofd_pqi_t [NPORT-1:0] pqi_r;
  logic [NPORT-1:0] ul_port_err; // Active outputs hit by supply loss
  logic [NPORT-1:0] port_err;

  assign ul_port_err = {NPORT{ul_f & ul_en}} & drive_r;
  assign port_err = ls_s | force_r | ul_port_err;

  // Indicators follow the synchronised pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      us_led_r <= 1'b0;
      ul_led_r <= 1'b0;
      pfi_r <= '0;
      pqi_r <= '0;
    end
    else
    begin
      us_led_r <= us_uv & us_en;
      ul_led_r <= ul_uv & ul_en;
      pfi_r <= ls_s | force_r;
      for (int p = 0; p < NPORT; p++)
      begin
        pqi_r[p].process_data_valid <= pdv_s[p];
        pqi_r[p].port_device_error <= port_err[p];
        pqi_r[p].device_communicating <= com_s[p];
        pqi_r[p].port_enabled_flag <= porten_r[p];
        pqi_r[p].rsvd <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic awready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic irq_r;

  // Ready is raised only when both address and data are waiting
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
  wire we = s_axi_awvalid & s_axi_wvalid & awready_r;
  wire rd_go = s_axi_arvalid & ~arready_r & ~rvalid_r;
  wire re = s_axi_arvalid & arready_r;
  wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] wm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd = s_axi_wdata & wm;
  wire w_cfg = we & (wa == OFF_CFG);
  wire w_dom = we & (wa == OFF_DOMODE);
  wire w_sco = we & (wa == OFF_SCOUT);
  wire w_pen = we & (wa == OFF_PORTEN);
  wire w_ist = we & (wa == OFF_IRQST);
  wire w_imk = we & (wa == OFF_IRQMSK);
  wire w_hit = w_cfg | w_dom | w_sco | w_pen | w_ist | w_imk;
  wire r_hit = (ra <= OFF_STATE);
  wire [31:0] rmux =
    (ra == OFF_CFG) ? cfg_r :
    (ra == OFF_DOMODE) ? domode_r :
    (ra == OFF_SCOUT) ? 32'(scout_r) :
    (ra == OFF_PORTEN) ? 32'(porten_r) :
    (ra == OFF_IRQST) ? 32'(irqst_r) :
    (ra == OFF_IRQMSK) ? 32'(irqmsk_r) :
    (ra == OFF_STATE) ? {16'h0000, force_r, drive_r} : 32'h0000_0000;

  wire [IRQ_W-1:0] irq_ev = {|cq_trip, |ls_rise, ul_rise & ul_en, us_rise};
  wire [IRQ_W-1:0] irq_w1c = w_ist ? wd[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irqst_nxt = (irqst_r & ~irq_w1c) | irq_ev;

  // Bus handshake flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      awready_r <= wr_go;
      if (we)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
      arready_r <= rd_go;
      if (re)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rmux;
        rresp_r <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // Register storage; strobes mask the written lanes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_r <= CFG_RST;
      domode_r <= DOMODE_RST;
      scout_r <= SCOUT_RST;
      porten_r <= PORTEN_RST;
      irqst_r <= '0;
      irqmsk_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (w_cfg)
        cfg_r <= ((cfg_r & ~wm) | wd) & CFG_MASK;
      if (w_dom)
        domode_r <= ((domode_r & ~wm) | wd) & DOMODE_MASK;
      if (w_sco & s_axi_wstrb[0])
        scout_r <= wd[NPORT-1:0];
      if (w_pen & s_axi_wstrb[0])
        porten_r <= wd[NPORT-1:0];
      if (w_imk & s_axi_wstrb[0])
        irqmsk_r <= wd[IRQ_W-1:0];
      irqst_r <= irqst_nxt;
      irq_r <= |(irqst_nxt & irqmsk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring

  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign out_a_drive = drive_r;
  assign us_led_red = us_led_r;
  assign ul_led_red = ul_led_r;
  assign port_fault_indicator = pfi_r;
  assign port_qualifier_byte = pqi_r;
  assign diag_valid = diag_valid_r;
  assign diag = diag_r;
  assign irq = irq_r;

endmodule : iofd_top

// ===== iofd_pkg.sv
package iofd_pkg;
  // Port count and clock
  localparam int NPORT = 8;
  localparam int CLK_PERIOD_NS = 10;
  // One millisecond filter step
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Automatic restart retry period, in clock cycles
  localparam int RESTART_CYC_DEF = 10_000_000;
  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_DOMODE = 8'h04;
  localparam logic [7:0] OFF_SCOUT = 8'h08;
  localparam logic [7:0] OFF_PORTEN = 8'h0C;
  localparam logic [7:0] OFF_IRQST = 8'h10;
  localparam logic [7:0] OFF_IRQMSK = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;
  // Configuration fields
  localparam int CFG_US_EN_BIT = 0;
  localparam int CFG_UL_EN_BIT = 1;
  localparam int CFG_FILT_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_5001;
  localparam logic [31:0] CFG_MASK = 32'h0000_FF03;
  // Output mode fields: digital out, source select, restart mode
  localparam int DO_EN_LSB = 0;
  localparam int DO_SRC_LSB = 8;
  localparam int DO_RSTM_LSB = 16;
  localparam logic [31:0] DOMODE_RST = 32'h0000_0000;
  localparam logic [31:0] DOMODE_MASK = 32'h00FF_FFFF;
  localparam logic [7:0] SCOUT_RST = 8'h00;
  localparam logic [7:0] PORTEN_RST = 8'hFF;
  // Interrupt status bits
  localparam int IRQ_US = 0;
  localparam int IRQ_UL = 1;
  localparam int IRQ_LS = 2;
  localparam int IRQ_CQ = 3;
  localparam int IRQ_W = 4;
  // Diagnostic channels and codes
  localparam logic [15:0] CH_GLOBAL = 16'h8000;
  localparam logic [15:0] CODE_US = 16'h0002;
  localparam logic [15:0] CODE_UL = 16'h0118;
  localparam logic [15:0] CODE_LSHORT = 16'h1806;
  localparam logic [15:0] CODE_CQSHORT = 16'h1811;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // One diagnostic message
  typedef struct packed {
    logic [15:0] chan;
    logic [15:0] code;
  } iofd_diag_t;
  // Qualifier byte appended to port input data
  typedef struct packed {
    logic process_data_valid;
    logic port_device_error;
    logic device_communicating;
    logic port_enabled_flag;
    logic [3:0] rsvd;
  } iofd_pqi_t;
endpackage : iofd_pkg

// ===== iofd_properties.sv
`timescale 1ns/100ps
module iofd_properties
  import iofd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  // Supplies, ports and indicators
  input wire logic us_undervolt,
  input wire logic ul_undervolt,
  input wire logic us_led_red,
  input wire logic ul_led_red,
  input wire logic [NPORT-1:0] sensor_short,
  input wire logic [NPORT-1:0] port_fault_indicator,
  input wire iofd_pqi_t [NPORT-1:0] port_qualifier_byte,
  // Diagnostic stream
  input wire logic diag_valid,
  input wire iofd_diag_t diag,
  input wire logic diag_ack
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Per-port flags pulled out of the qualifier bytes
  logic [NPORT-1:0] err_v;
  logic [NPORT-1:0] rsvd_v;
  for (genvar p = 0; p < NPORT; p++)
  begin : g_pq
    assign err_v[p] = port_qualifier_byte[p].port_device_error;
    assign rsvd_v[p] = |port_qualifier_byte[p].rsvd;
  end
  // Legal channel and code pairs
  wire port_ch = diag.chan >= 16'h0001 && diag.chan <= 16'h0008;
  wire port_code = diag.code == CODE_LSHORT || diag.code == CODE_CQSHORT;
  wire glob_code = diag.code == CODE_US || diag.code == CODE_UL;
  ////////////////////////////////////////////////////////////////////////////////
  diag_hold_a: assert property (diag_valid && !diag_ack |=> diag_valid && $stable(diag))
    else $error("diagnostic changed before ack");
  diag_kind_a: assert property (diag_valid |-> ((diag.chan == CH_GLOBAL) ? glob_code : (port_ch && port_code)))
    else $error("diagnostic channel or code off");
  us_led_off_a: assert property ((!us_undervolt) [*4] |-> !us_led_red)
    else $error("supply lamp lit without undervoltage");
  us_led_cause_a: assert property (us_led_red |-> $past(us_undervolt, 3))
    else $error("supply lamp lit early");
  ul_led_cause_a: assert property (ul_led_red |-> $past(ul_undervolt, 3))
    else $error("actuator lamp lit early");
  fault_err_a: assert property ((port_fault_indicator & ~err_v) == '0)
    else $error("port lamp without error flag");
  pqi_rsvd_a: assert property (rsvd_v == '0)
    else $error("qualifier low bits not zero");
  short_lamp_a: assert property (sensor_short[0] [*4] |-> port_fault_indicator[0] && err_v[0])
    else $error("sensor short not shown");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
    else $error("write answer late");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  // Main scenarios reached
  ack_c: cover property (diag_valid && diag_ack);
  lamp_c: cover property (port_fault_indicator[0]);
  led_c: cover property (ul_led_red);
endmodule : iofd_properties
bind iofd_top iofd_properties chk (.aclk, .aresetn, .s_axi_awready, .s_axi_arready,
  .s_axi_bvalid, .s_axi_rvalid, .us_undervolt, .ul_undervolt, .us_led_red, .ul_led_red,
  .sensor_short, .port_fault_indicator, .port_qualifier_byte, .diag_valid, .diag, .diag_ack);

// ===== iofd_plc_model.sv
`timescale 1ns/100ps
module iofd_plc_model
  import iofd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls: commands, filler bits, ack delay
  input wire logic [NPORT-1:0] cmd,
  input wire logic [NPORT*8-1:0] fill,
  input wire logic [3:0] ack_wait,
  // Block side
  output logic [NPORT*8-1:0] port_out_bytes,
  input wire logic diag_valid,
  input wire iofd_diag_t diag,
  output logic diag_ack
);
  iofd_diag_t got[$]; // Diagnostics received, oldest first
  logic [3:0] wait_r; // Cycles already spent before ack
  ////////////////////////////////////////////////////////////////////////////////
  // Command in bit 0; upper bits are noise so only bit 0 may matter
  for (genvar p = 0; p < NPORT; p++)
  begin : g_byte
    assign port_out_bytes[8*p +: 8] = {fill[8*p+1 +: 7], cmd[p]};
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Slow or prompt one-cycle ack; never acks the same message twice
  always_ff @(posedge aclk)
  begin
    diag_ack <= 1'b0;
    if (!aresetn)
      wait_r <= 4'h0;
    else if (diag_valid && !diag_ack)
    begin
      if (wait_r >= ack_wait)
      begin
        got.push_back(diag);
        diag_ack <= 1'b1;
        wait_r <= 4'h0;
      end
      else
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule : iofd_plc_model

// ===== test_io_port_fault_diagnostics.sv
`timescale 1ns/100ps
module test_io_port_fault_diagnostics
  import iofd_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NPORT*8-1:0] port_out_bytes, fill;
  logic us_fault, ul_fault, us_undervolt, ul_undervolt, us_led_red, ul_led_red;
  logic [NPORT-1:0] sensor_short, out_a_short, dev_comm_in, pd_valid_in, out_a_drive, cmd;
  logic [NPORT-1:0] port_fault_indicator;
  iofd_pqi_t [NPORT-1:0] port_qualifier_byte;
  iofd_diag_t diag;
  logic diag_valid, diag_ack, irq;
  logic [3:0] ack_wait;
  int seed = 32263;
  int error_cnt = 0;
  int checks = 0;
  // Short filter tick and retry beat keep the run brief
  iofd_top #(.MS_CYC_P(10), .RESTART_CYC(50)) uut (.*);
  iofd_plc_model plc (.*);
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and counts, shared by the sequence and the watchdog
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_v
  // Next received diagnostic, all ones if none came in time
  task automatic cmp_diag(input logic [15:0] ch, input logic [15:0] code);
    iofd_diag_t d;
    d = '1;
    repeat (300) if (plc.got.size() == 0) @(posedge aclk);
    if (plc.got.size() != 0) d = plc.got.pop_front();
    cmp_v(d, {ch, code});
  endtask : cmp_diag
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Bounded wait on port 0 output state
  task automatic wait_drive(input logic v, input int lim);
    repeat (lim) if (out_a_drive[0] !== v) @(posedge aclk);
  endtask : wait_drive
  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: hold each channel until its ready, answer taken at same edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Address and data are each released on their own ready
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
      s_axi_awvalid <= ~aw_ok;
      s_axi_wvalid <= ~w_ok;
    end
    // Ready lines stay high between calls so no step assigns them twice
    do @(posedge aclk); while (!s_axi_bvalid);
    cmp_v(s_axi_bresp, er);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    cmp_v(s_axi_rdata, ed);
    cmp_v(s_axi_rresp, er);
  endtask : axr
  // Expected drive: status/control bits where selected, else the command
  function automatic logic [7:0] exp_drive(input logic [7:0] c, s, src);
    return (c & ~src) | (s & src);
  endfunction : exp_drive
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about 2000 cycles
  initial
  begin
    #200_000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, us_fault, ul_fault, us_undervolt} = '0;
    {ul_undervolt, sensor_short, out_a_short, dev_comm_in, pd_valid_in, cmd, fill} = '0;
    s_axi_wstrb = 4'hF;
    ack_wait = 4'h0;
    tick(4);
    aresetn <= 1'b1;
    tick(1);
    // Reset values and an unmapped place
    axr(OFF_CFG, CFG_RST, RESP_OKAY);
    axr(OFF_PORTEN, {24'h00_0000, PORTEN_RST}, RESP_OKAY);
    axr(8'h40, 32'h0000_0000, RESP_SLVERR);
    axw(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    cmp_v(port_qualifier_byte[3].port_enabled_flag, 1'b1);
    $display("test registers done");
    // Random commands, upper ports from status/control bits
    axw(OFF_DOMODE, 32'h0000_F0FF, RESP_OKAY);
    axw(OFF_SCOUT, 32'h0000_00A0, RESP_OKAY);
    repeat (8)
    begin
      cmd <= 8'($random(seed));
      fill <= {$random(seed), $random(seed)};
      pd_valid_in <= 8'($random(seed));
      dev_comm_in <= 8'($random(seed));
      tick(4);
      cmp_v(out_a_drive, exp_drive(cmd, 8'hA0, 8'hF0));
      for (int p = 0; p < NPORT; p++)
        cmp_v({port_qualifier_byte[p][7], port_qualifier_byte[p][5]}, {pd_valid_in[p], dev_comm_in[p]});
    end
    $display("test outputs done");
    // Short held from the rise: filtered 80 ms, then trip and auto retry
    axw(OFF_DOMODE, 32'h0000_00FF, RESP_OKAY);
    cmd <= 8'h00;
    tick(4);
    cmd <= 8'h01;
    out_a_short <= 8'h01;
    tick(700);
    cmp_v(out_a_drive[0], 1'b1);
    wait_drive(1'b0, 200);
    cmp_v(out_a_drive[0], 1'b0);
    // Lamp looked at before the retry beat can release the fault
    cmp_v(port_fault_indicator, 8'h01);
    cmp_diag(16'h0001, CODE_CQSHORT);
    wait_drive(1'b1, 60);
    cmp_v(out_a_drive[0], 1'b1);
    out_a_short <= 8'h00;
    $display("test auto restart done");
    // Restart after reset: command must go low before high
    axw(OFF_CFG, 32'h0000_0001, RESP_OKAY);
    axw(OFF_DOMODE, 32'h0001_00FF, RESP_OKAY);
    out_a_short <= 8'h01;
    wait_drive(1'b0, 1000);
    cmp_diag(16'h0001, CODE_CQSHORT);
    out_a_short <= 8'h00;
    tick(120);
    cmp_v(out_a_drive[0], 1'b0);
    cmd <= 8'h00;
    tick(4);
    cmd <= 8'h01;
    tick(4);
    cmp_v(out_a_drive[0], 1'b1);
    $display("test reset restart done");
    // Supplies, lamps and the interrupt
    cmp_v(irq, 1'b0);
    axw(OFF_IRQMSK, 32'h0000_0001, RESP_OKAY);
    us_undervolt <= 1'b1;
    us_fault <= 1'b1;
    cmp_diag(CH_GLOBAL, CODE_US);
    tick(2);
    cmp_v({us_led_red, irq}, 2'b11);
    axr(OFF_IRQST, 32'h0000_0009, RESP_OKAY);
    axw(OFF_IRQST, 32'h0000_0009, RESP_OKAY);
    tick(3);
    cmp_v(irq, 1'b0);
    ul_undervolt <= 1'b1;
    ul_fault <= 1'b1;
    tick(8);
    cmp_v({ul_led_red, 8'(plc.got.size())}, 9'h000);
    ul_fault <= 1'b0;
    axw(OFF_CFG, 32'h0000_0003, RESP_OKAY);
    tick(5);
    cmp_v(ul_led_red, 1'b1);
    ul_fault <= 1'b1;
    cmp_diag(CH_GLOBAL, CODE_UL);
    cmp_diag(16'h0001, CODE_CQSHORT);
    {us_fault, ul_fault, us_undervolt, ul_undervolt} <= 4'h0;
    $display("test supplies done");
    // All sensor shorts at once, slow acks, lowest port first
    ack_wait <= 4'h5;
    sensor_short <= 8'hFF;
    for (int p = 1; p <= NPORT; p++)
      cmp_diag(16'(p), CODE_LSHORT);
    cmp_v(port_fault_indicator, 8'hFF);
    axw(OFF_PORTEN, 32'h0000_000F, RESP_OKAY);
    tick(3);
    cmp_v(port_qualifier_byte[7].port_enabled_flag, 1'b0);
    cmp_v(plc.got.size(), 32'h0000_0000);
    $display("test sensor shorts done");
    wrap_up();
  end
endmodule : test_io_port_fault_diagnostics
